// File: design/poer_regs.sv
// OTG event registers and accessory routing control
`timescale 1ns/1ns
module poer_regs
(
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        resetn,
  // Register port
  input  wire logic [poer_pkg::ADDR_W-1:0] addr,
  input  wire logic [poer_pkg::DATA_W-1:0] wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  output logic      [poer_pkg::DATA_W-1:0] rdata,
  // OTG comparators and mode
  input  wire logic                        detach_in,
  input  wire logic                        bus_power_ok_in,
  input  wire logic                        session_power_ok,
  input  wire logic                        session_power_gone,
  input  wire logic                        otg_id_low,
  input  wire logic                        host_mode,
  input  wire logic [1:0]                  line_state,
  // Link pins
  input  wire logic                        link_clk,
  input  wire logic                        link_stop,
  input  wire logic                        data0_in,
  output logic                             data1_out,
  output logic                             data1_oen,
  // USB lines
  input  wire logic                        dp_in,
  output logic                             dm_out,
  output logic                             dm_oen,
  output logic                             se_rx_en,
  // Accessory switches
  output logic                             otg_id_pull_low,
  output logic                             left_audio_route,
  output logic                             right_mono_route,
  output logic                             left_audio_pin,
  output logic                             right_mono_pin,
  output logic                             accessory_port_select
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  poer_sig_if sig ();

  wire logic [poer_pkg::SIG_W-1:0] raw_in = {line_state, data0_in, dp_in, link_stop,
                                             link_clk, host_mode, otg_id_low,
                                             session_power_gone, session_power_ok,
                                             bus_power_ok_in, detach_in};

  poer_sync_edge u_sync
  (
    .clk    (clk),
    .resetn (resetn),
    .raw    (raw_in),
    .sig    (sig)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] rise_en;
  logic [7:0] fall_en;
  logic [7:0] latch;
  logic [7:0] scratch;
  logic [7:0] acc;
  logic [7:0] ifc;

  // ----------------------------------------------------------------
  // Alias update
  // ----------------------------------------------------------------
  function automatic logic [7:0] poer_upd(input logic [7:0] old, input logic [7:0] wd,
                                          input logic [1:0] op);
    logic [7:0] res;
    res = old;
    case (op)
      poer_pkg::OP_WRITE: res = wd;
      poer_pkg::OP_SET:   res = old | wd;
      poer_pkg::OP_CLEAR: res = old & ~wd;
      default:            res = old;
    endcase
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic [5:0] off_rise = addr - poer_pkg::RISE_ADDR;
  wire logic [5:0] off_fall = addr - poer_pkg::FALL_ADDR;
  wire logic [5:0] off_scr  = addr - poer_pkg::SCRATCH_ADDR;
  wire logic [5:0] off_acc  = addr - poer_pkg::ACC_ADDR;
  wire logic [5:0] off_ifc  = addr - poer_pkg::IFC_ADDR;
  wire logic       in_rise  = (addr >= poer_pkg::RISE_ADDR) && (off_rise < 6'h03);
  wire logic       in_fall  = (addr >= poer_pkg::FALL_ADDR) && (off_fall < 6'h03);
  wire logic       in_scr   = (addr >= poer_pkg::SCRATCH_ADDR) && (off_scr < 6'h03);
  wire logic       in_acc   = (addr >= poer_pkg::ACC_ADDR) && (off_acc < 6'h03);
  wire logic       in_ifc   = (addr >= poer_pkg::IFC_ADDR) && (off_ifc < 6'h03);
  wire logic       rd_latch = rd && (addr == poer_pkg::LATCH_ADDR);

  // ----------------------------------------------------------------
  // Next register values
  // ----------------------------------------------------------------
  wire logic [7:0] next_rise_en = (wr && in_rise)
                                ? poer_upd(rise_en, wdata, off_rise[1:0]) & poer_pkg::EDGE_MASK
                                : rise_en;                                            // [R1] [R4]
  wire logic [7:0] next_fall_en = (wr && in_fall)
                                ? poer_upd(fall_en, wdata, off_fall[1:0]) & poer_pkg::EDGE_MASK
                                : fall_en;                                            // [R2] [R4]
  wire logic [7:0] next_scratch = (wr && in_scr)
                                ? poer_upd(scratch, wdata, off_scr[1:0])
                                : scratch;                                            // [R9] [R4]
  wire logic [7:0] next_acc     = (wr && in_acc)
                                ? poer_upd(acc, wdata, off_acc[1:0]) & poer_pkg::ACC_MASK
                                : acc;                                                // [R4]

  // ----------------------------------------------------------------
  // Edge events
  // ----------------------------------------------------------------
  wire logic [7:0] host_gate = {7'h7F, sig.lvl[poer_pkg::SIG_HOST]};                 // [R3]
  wire logic [7:0] rise_evt  = {3'h0, sig.rise[4:0]} & rise_en & host_gate;          // [R1]
  wire logic [7:0] fall_evt  = {3'h0, sig.fall[4:0]} & fall_en & host_gate;          // [R2]
  wire logic [7:0] evt       = rise_evt | fall_evt;
  wire logic [7:0] next_latch = (rd_latch ? 8'h00 : latch) | evt;                     // [R7] [R20]

  // ----------------------------------------------------------------
  // Accessory mode exit on a stop seen at a link clock edge
  // ----------------------------------------------------------------
  wire logic       acc_exit = sig.rise[poer_pkg::SIG_LCLK] && sig.lvl[poer_pkg::SIG_STOP];
  wire logic [7:0] ifc_sw   = (wr && in_ifc)
                            ? poer_upd(ifc, wdata, off_ifc[1:0]) & poer_pkg::IFC_MASK
                            : ifc;
  wire logic       ifc_keep = (wr && in_ifc) ? ifc_sw[poer_pkg::IFC_ACC_BIT] : 1'b0;
  wire logic [7:0] next_ifc = (acc_exit && !ifc_keep)
                            ? (ifc_sw & ~poer_pkg::IFC_MASK)
                            : ifc_sw;                                                 // [R19]

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rise_en <= poer_pkg::EDGE_EN_RST;                                               // [R1]
      fall_en <= poer_pkg::EDGE_EN_RST;                                               // [R2]
      latch   <= 8'h00;
      scratch <= poer_pkg::SCRATCH_RST;                                               // [R9]
      acc     <= poer_pkg::ACC_RST;
      ifc     <= 8'h00;
    end
    else
    begin
      rise_en <= next_rise_en;
      fall_en <= next_fall_en;
      latch   <= next_latch;
      scratch <= next_scratch;
      acc     <= next_acc;
      ifc     <= next_ifc;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb
  begin
    rd_mux = 8'h00;
    if (in_rise)
      rd_mux = rise_en;
    else if (in_fall)
      rd_mux = fall_en;
    else if (addr == poer_pkg::STATUS_ADDR)
      rd_mux = {3'h0, sig.lvl[4:0]};                                                  // [R5] [R6]
    else if (addr == poer_pkg::LATCH_ADDR)
      rd_mux = latch;
    else if (addr == poer_pkg::DEBUG_ADDR)
      rd_mux = {6'h00, sig.lvl[poer_pkg::SIG_LS +: 2]};                               // [R8]
    else if (in_scr)
      rd_mux = scratch;
    else if (in_acc)
      rd_mux = acc;
    else if (in_ifc)
      rd_mux = ifc;
  end

  wire logic [7:0] next_rdata = rd ? rd_mux : 8'h00;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata <= 8'h00;
    else
      rdata <= next_rdata;
  end

  // ----------------------------------------------------------------
  // Routing
  // ----------------------------------------------------------------
  wire logic acc_on    = ifc[poer_pkg::IFC_ACC_BIT];
  wire logic tx_route  = acc[poer_pkg::TX_ROUTE_BIT];
  wire logic rx_route  = acc[poer_pkg::RX_ROUTE_BIT];
  wire logic left_sw   = acc[poer_pkg::LEFT_BIT];
  wire logic right_sw  = acc[poer_pkg::RIGHT_BIT] | acc[poer_pkg::MIC_BIT];           // [R15]
  wire logic dp_lvl    = sig.lvl[poer_pkg::SIG_DP];
  wire logic d0_lvl    = sig.lvl[poer_pkg::SIG_DATA0];

  wire logic next_data1_out  = rx_route ? dp_lvl : 1'b1;                              // [R11] [R12]
  wire logic next_data1_oen  = !acc_on;
  wire logic next_dm_out     = tx_route ? d0_lvl : 1'b0;                              // [R12]
  wire logic next_dm_oen     = !(acc_on && tx_route);                                 // [R12]
  wire logic next_se_rx_en   = !(left_sw || right_sw);                                // [R18]
  wire logic next_left_pin   = left_sw && acc_on && tx_route && d0_lvl;               // [R16]
  wire logic next_right_pin  = right_sw && acc_on && rx_route && dp_lvl;              // [R16]

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      data1_out        <= 1'b1;
      data1_oen        <= 1'b1;
      dm_out           <= 1'b0;
      dm_oen           <= 1'b1;
      se_rx_en         <= 1'b1;
      otg_id_pull_low  <= 1'b0;
      left_audio_route <= 1'b0;
      right_mono_route <= 1'b0;
      left_audio_pin   <= 1'b0;
      right_mono_pin   <= 1'b0;
    end
    else
    begin
      data1_out        <= next_data1_out;
      data1_oen        <= next_data1_oen;
      dm_out           <= next_dm_out;
      dm_oen           <= next_dm_oen;
      se_rx_en         <= next_se_rx_en;
      otg_id_pull_low  <= acc[poer_pkg::ID_PULL_BIT];                                 // [R13]
      left_audio_route <= left_sw;                                                    // [R14]
      right_mono_route <= right_sw;                                                   // [R15]
      left_audio_pin   <= next_left_pin;
      right_mono_pin   <= next_right_pin;
    end
  end

  assign accessory_port_select = acc_on;                                              // [R19]

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence seq_latch_read;
    rd && (addr == poer_pkg::LATCH_ADDR);
  endsequence

  sequence seq_quiet_edges;
    (sig.rise[4:0] == 5'h00) && (sig.fall[4:0] == 5'h00);
  endsequence

  sequence seq_scratch_set;
    wr && (addr == poer_pkg::SCRATCH_ADDR + 6'h01);
  endsequence

  property p_latch_sets;
    (sig.rise[1] && rise_en[1]) |=> latch[1];
  endproperty

  property p_read_clears;
    (seq_latch_read and seq_quiet_edges) |=> (latch == 8'h00) ##1 (latch == 8'h00 || evt != 8'h00
                                                                   || $past(evt) != 8'h00);
  endproperty

  AST_LATCH_SET: assert property (p_latch_sets)                                       // [R7]
    else $error("enabled rising edge did not set latch");

  AST_FALL_SET: assert property ((sig.fall[3] && fall_en[3]) |=> latch[3])          // [R2]
    else $error("enabled falling edge did not set latch");

  AST_HOST_GATE: assert property (
    (!sig.lvl[poer_pkg::SIG_HOST] && !latch[0]) |=> !latch[0])                       // [R3]
    else $error("detach event latched outside host mode");

  AST_READ_CLEAR: assert property (p_read_clears)                                     // [R7]
    else $error("latch read did not clear");

  AST_SET_WINS: assert property (
    (seq_latch_read ##0 (evt != 8'h00)) |=> ((latch & $past(evt)) == $past(evt)))    // [R20]
    else $error("event lost during latch read");

  AST_STATUS_LIVE: assert property (
    (rd && addr == poer_pkg::STATUS_ADDR) |=> rdata == {3'h0, $past(sig.lvl[4:0])})  // [R5]
    else $error("status read not live");

  AST_DEBUG_ZERO: assert property (
    (rd && addr == poer_pkg::DEBUG_ADDR) |=> (rdata[7:2] == 6'h00)
      && (rdata[1:0] == $past(sig.lvl[poer_pkg::SIG_LS +: 2])))                      // [R8]
    else $error("debug read wrong");

  AST_ALIAS_SET: assert property (
    seq_scratch_set |=> scratch == ($past(scratch) | $past(wdata)))                  // [R4]
    else $error("set alias failed");

  AST_SE_RX_OFF: assert property (
    (left_sw || right_sw) |=> !se_rx_en)                                              // [R18]
    else $error("single-ended receivers not disabled");

  AST_DATA1_HIGH: assert property ((!rx_route) |=> data1_out)                        // [R11]
    else $error("data bit 1 not held high");

  AST_RIGHT_SW: assert property (
    (!acc[poer_pkg::RIGHT_BIT] && !acc[poer_pkg::MIC_BIT]) |=> !right_mono_route)    // [R15]
    else $error("right audio switch closed with both bits clear");

  AST_ID_PULL: assert property (
    acc[poer_pkg::ID_PULL_BIT] |=> otg_id_pull_low)                                   // [R13]
    else $error("ID pull not applied");

  AST_LEFT_SW: assert property (
    left_sw |=> left_audio_route ##1 (left_audio_route || !$past(left_sw)))           // [R14]
    else $error("left audio switch not closed");

  AST_ACC_EXIT: assert property (
    (acc_exit && acc_on && !(wr && in_ifc)) |=> !accessory_port_select)               // [R19]
    else $error("accessory mode not left on stop");

endmodule // poer_regs

// File: design/poer_sync_edge.sv
// Two-stage synchronisers with edge detection for all pin inputs
`timescale 1ns/1ns
module poer_sync_edge
(
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       resetn,
  // Raw pins
  input  wire logic [poer_pkg::SIG_W-1:0] raw,
  // Synchronised outputs
  poer_sig_if.src                         sig
);

  logic [poer_pkg::SIG_W-1:0] meta;
  logic [poer_pkg::SIG_W-1:0] sync;
  logic [poer_pkg::SIG_W-1:0] prev;
  logic [2:0]                 warm;

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
      warm <= 3'h0;
    end
    else
    begin
      meta <= raw;
      sync <= meta;
      prev <= sync;
      warm <= {warm[1:0], 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // Levels and edges
  // ----------------------------------------------------------------
  // Edges held off until prev holds a real sample: no false edge after reset
  wire logic [poer_pkg::SIG_W-1:0] armed = {poer_pkg::SIG_W{warm[2]}};

  assign sig.lvl  = sync;
  assign sig.rise = sync & ~prev & armed;
  assign sig.fall = ~sync & prev & armed;

endmodule // poer_sync_edge

// File: inc/poer_pkg.sv
// Constants for the OTG event and accessory register bank
// Function
// R1: Five rising-edge enables, bits 0-4, default one
// R2: Five falling-edge enables, bits 0-4, default one
// R3: Detach edges count only in host mode
// R4: Control registers answer write, set, clear aliases
// R5: Status shows live five monitored signals
// R6: Status after reset follows real comparators
// R7: Enabled edges set latch; reading clears it
// R8: Debug shows line state, upper bits zero
// R9: Scratch byte, reset zero, no side effects
// R10: Link programs routing before accessory mode
// R11: Data bit 1 high while receive route off
// R12: Bit 2 routes transmit, bit 3 receive
// R13: Bit 1 pulls ID pin low
// R14: Bit 4 connects D- to left audio
// R15: Bit 5 or 6 connects D+ to right
// R16: UART data appears on enabled audio pins
// R17: Software avoids UART routes with audio on
// R18: Single-ended receivers off with any audio route
// R19: Accessory mode bit set by link, device clears
// R20: Edge during latch read stays latched
package poer_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 6;
  localparam int          DATA_W       = 8;
  localparam logic [5:0]  IFC_ADDR     = 6'h07;
  localparam logic [5:0]  RISE_ADDR    = 6'h0D;
  localparam logic [5:0]  FALL_ADDR    = 6'h10;
  localparam logic [5:0]  STATUS_ADDR  = 6'h13;
  localparam logic [5:0]  LATCH_ADDR   = 6'h14;
  localparam logic [5:0]  DEBUG_ADDR   = 6'h15;
  localparam logic [5:0]  SCRATCH_ADDR = 6'h16;
  localparam logic [5:0]  ACC_ADDR     = 6'h19;
  localparam logic [1:0]  OP_WRITE     = 2'h0;
  localparam logic [1:0]  OP_SET       = 2'h1;
  localparam logic [1:0]  OP_CLEAR     = 2'h2;

  // ----------------------------------------------------------------
  // Reset values and field masks
  // ----------------------------------------------------------------
  localparam logic [7:0]  EDGE_EN_RST  = 8'h1F;
  localparam logic [7:0]  EDGE_MASK    = 8'h1F;
  localparam logic [7:0]  SCRATCH_RST  = 8'h00;
  localparam logic [7:0]  ACC_RST      = 8'h00;
  localparam logic [7:0]  ACC_MASK     = 8'h7E;
  localparam logic [7:0]  IFC_MASK     = 8'h04;
  localparam int          IFC_ACC_BIT  = 2;
  localparam int          ID_PULL_BIT  = 1;
  localparam int          TX_ROUTE_BIT = 2;
  localparam int          RX_ROUTE_BIT = 3;
  localparam int          LEFT_BIT     = 4;
  localparam int          RIGHT_BIT    = 5;
  localparam int          MIC_BIT      = 6;

  // ----------------------------------------------------------------
  // Synchronised input vector layout
  // ----------------------------------------------------------------
  localparam int          SIG_W        = 12;
  localparam int          SIG_DETACH   = 0;
  localparam int          SIG_HOST     = 5;
  localparam int          SIG_LCLK     = 6;
  localparam int          SIG_STOP     = 7;
  localparam int          SIG_DP       = 8;
  localparam int          SIG_DATA0    = 9;
  localparam int          SIG_LS       = 10;

endpackage

// File: inc/poer_sig_if.sv
// Synchronised levels and edge pulses between sampler and register bank
`timescale 1ns/1ns
interface poer_sig_if;
  logic [poer_pkg::SIG_W-1:0] lvl;
  logic [poer_pkg::SIG_W-1:0] rise;
  logic [poer_pkg::SIG_W-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface

// File: sim/poer_link_model.sv
// Link controller model driving the link clock, stop and transmit data pins
`timescale 1ns/1ns
module poer_link_model
(
  // Commands from the bench
  input  wire logic run,
  input  wire logic stop_req,
  input  wire logic txd,
  // Link pins
  output logic      link_clk,
  output logic      link_stop,
  output logic      data0_in
);
  // ----------------------------------------------------------------
  // Link clock, 160 ns period, parked low outside frames
  // ----------------------------------------------------------------
  initial
  begin
    link_clk  = 1'b0;
    link_stop = 1'b0;
  end

  always #80
  begin
    if (run || link_clk)
      link_clk = ~link_clk;
  end

  // ----------------------------------------------------------------
  // Stop changes on the falling link edge, seen at the next rise
  // ----------------------------------------------------------------
  always @(negedge link_clk)
    link_stop <= stop_req;

  // UART transmit data is asynchronous to the link clock
  assign data0_in = txd;

endmodule // poer_link_model

// File: sim/poer_regs_test.sv
// Self-checking bench for the OTG event and accessory register bank
`timescale 1ns/1ns
`define CHK(name, want, got) begin compares++; if ((got) !== (want)) begin num_errors++; \
  $display("unexpected %s: expected %0h seen %0h", name, want, got); end end
module poer_regs_test;
  localparam logic [5:0] BASES [5] = '{6'h07, 6'h0D, 6'h10, 6'h19, 6'h16};
  localparam logic [7:0] MASKS [5] = '{8'h04, 8'h1F, 8'h1F, 8'h7E, 8'hFF};
  localparam logic [7:0] RSTS  [5] = '{8'h00, 8'h1F, 8'h1F, 8'h00, 8'h00};
  localparam logic [7:0] AUD   [8] = '{8'h02, 8'h10, 8'h20, 8'h40, 8'h60, 8'h1C, 8'h6C, 8'h00};
  logic       clk, resetn, wr, rd, host_mode, run, stop_req, txd, dp_in;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, rise_en, fall_en;
  logic [4:0] pins;
  logic [1:0] line_state;
  logic       link_clk, link_stop, data0_in, data1_out, data1_oen, dm_out, dm_oen, se_rx_en;
  logic       otg_id_pull_low, left_audio_route, right_mono_route, left_audio_pin;
  logic       right_mono_pin, accessory_port_select;
  int         num_errors, compares;

  // ----------------------------------------------------------------
  // Design and link partner
  // ----------------------------------------------------------------
  poer_regs poer_regs_i (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .detach_in(pins[0]), .bus_power_ok_in(pins[1]),
    .session_power_ok(pins[2]), .session_power_gone(pins[3]), .otg_id_low(pins[4]),
    .host_mode(host_mode), .line_state(line_state), .link_clk(link_clk),
    .link_stop(link_stop), .data0_in(data0_in), .data1_out(data1_out),
    .data1_oen(data1_oen), .dp_in(dp_in), .dm_out(dm_out), .dm_oen(dm_oen),
    .se_rx_en(se_rx_en), .otg_id_pull_low(otg_id_pull_low),
    .left_audio_route(left_audio_route), .right_mono_route(right_mono_route),
    .left_audio_pin(left_audio_pin), .right_mono_pin(right_mono_pin),
    .accessory_port_select(accessory_port_select));
  poer_link_model poer_link_model_i (.run(run), .stop_req(stop_req), .txd(txd),
    .link_clk(link_clk), .link_stop(link_stop), .data0_in(data0_in));

  // ----------------------------------------------------------------
  // Clock, tasks and closing
  // ----------------------------------------------------------------
  always #5 clk = ~clk;

  task wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  task reg_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task reg_rd(input logic [5:0] a, input logic [7:0] want);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    `CHK($sformatf("rdata at %0h", a), want, rdata)
    @(posedge clk);
  endtask

  // Moves the five comparator pins and checks status and latch
  task pins_to(input logic [4:0] v, input logic collide);
    logic [7:0] want;
    want = {3'h0, (rise_en[4:0] & v & ~pins) | (fall_en[4:0] & pins & ~v)};
    if (!host_mode)
      want[0] = 1'b0;
    @(posedge clk);
    pins <= v;
    if (collide)
    begin
      @(posedge clk);
      reg_rd(poer_pkg::LATCH_ADDR, 8'h00);
    end
    else
      wait_clk(6);
    reg_rd(poer_pkg::STATUS_ADDR, {3'h0, v});
    reg_rd(poer_pkg::LATCH_ADDR, want);
    reg_rd(poer_pkg::LATCH_ADDR, 8'h00);
  endtask

  task results;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Tests take a few hundred cycles; this cuts a hang short
  initial
  begin
    #200000;
    num_errors++;
    results;
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0; resetn = 1'b0; addr = 6'h00; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
    pins = 5'h08; host_mode = 1'b0; line_state = 2'h0; run = 1'b0; stop_req = 1'b0;
    txd = 1'b0; dp_in = 1'b0; num_errors = 0; compares = 0; rise_en = 8'h1F; fall_en = 8'h1F;
    wait_clk(4);
    resetn <= 1'b1;
    wait_clk(6);
    reg_rd(poer_pkg::STATUS_ADDR, 8'h08);
    reg_rd(poer_pkg::LATCH_ADDR, 8'h00);
    `CHK("se_rx_en", 1'b1, se_rx_en)
    `CHK("data1_out", 1'b1, data1_out)
    $display("test reset done");
    for (int i = 0; i < 5; i++)
    begin
      reg_rd(BASES[i], RSTS[i]);
      reg_wr(BASES[i], 8'hFF);
      reg_rd(BASES[i] + 6'h2, MASKS[i]);
      reg_wr(BASES[i] + 6'h2, 8'h0F);
      reg_rd(BASES[i] + 6'h1, MASKS[i] & 8'hF0);
      reg_wr(BASES[i] + 6'h1, 8'h03);
      reg_rd(BASES[i], MASKS[i] & 8'hF3);
      reg_wr(BASES[i], RSTS[i]);
    end
    reg_wr(poer_pkg::SCRATCH_ADDR, 8'hFF);
    wait_clk(3);
    `CHK("se_rx_en", 1'b1, se_rx_en)
    `CHK("accessory_port_select", 1'b0, accessory_port_select)
    reg_wr(6'h3F, 8'hFF);
    reg_rd(6'h3F, 8'h00);
    $display("test aliases done");
    for (int i = 0; i < 4; i++)
    begin
      line_state <= i[1:0];
      wait_clk(4);
      reg_rd(poer_pkg::DEBUG_ADDR, {6'h00, i[1:0]});
    end
    $display("test debug done");
    host_mode <= 1'b1;
    rise_en = 8'h0A;
    fall_en = 8'h14;
    reg_wr(poer_pkg::RISE_ADDR, rise_en);
    reg_wr(poer_pkg::FALL_ADDR, fall_en);
    pins_to(5'h1F, 1'b0);
    pins_to(5'h00, 1'b0);
    pins_to(5'h1F, 1'b0);
    host_mode <= 1'b0;
    rise_en = 8'h1F;
    fall_en = 8'h1F;
    reg_wr(poer_pkg::RISE_ADDR + 6'h1, 8'h15);
    reg_wr(poer_pkg::FALL_ADDR + 6'h1, 8'h0B);
    pins_to(5'h00, 1'b0);
    pins_to(5'h01, 1'b0);
    pins_to(5'h11, 1'b1);
    $display("test events done");
    reg_wr(poer_pkg::ACC_ADDR, 8'h0C);
    reg_wr(poer_pkg::IFC_ADDR + 6'h1, 8'h04);
    for (int i = 0; i < 4; i++)
    begin
      txd   <= i[0];
      dp_in <= i[1];
      wait_clk(6);
      `CHK("dm_out", i[0], dm_out)
      `CHK("data1_out", i[1], data1_out)
      `CHK("drive enables", 2'b00, {dm_oen, data1_oen})
    end
    dp_in <= 1'b0;
    reg_wr(poer_pkg::ACC_ADDR + 6'h2, 8'h08);
    wait_clk(6);
    `CHK("data1_out", 1'b1, data1_out)
    dp_in <= 1'b1;
    // ID pull alone first, then audio routes alone; UART routes joined only in the last mixed entries
    for (int i = 0; i < 8; i++)
    begin
      reg_wr(poer_pkg::ACC_ADDR, AUD[i]);
      wait_clk(6);
      `CHK("otg_id_pull_low", AUD[i][1], otg_id_pull_low)
      `CHK("left_audio_route", AUD[i][4], left_audio_route)
      `CHK("right_mono_route", AUD[i][5] | AUD[i][6], right_mono_route)
      `CHK("se_rx_en", ~|AUD[i][6:4], se_rx_en)
      `CHK("left_audio_pin", AUD[i][4] & AUD[i][2], left_audio_pin)
      `CHK("right_mono_pin", (AUD[i][5] | AUD[i][6]) & AUD[i][3], right_mono_pin)
    end
    run <= 1'b1;
    wait_clk(40);
    `CHK("accessory_port_select", 1'b1, accessory_port_select)
    stop_req <= 1'b1;
    wait_clk(40);
    reg_rd(poer_pkg::IFC_ADDR, 8'h00);
    `CHK("data1_oen", 1'b1, data1_oen)
    run      <= 1'b0;
    stop_req <= 1'b0;
    $display("test accessory done");
    results;
  end

endmodule // poer_regs_test
